// *** ram_pkg.sv ***
// Package for the range alarm monitor: widths, field codes, reset values.
// Assumes conversion results arrive as one-cycle strobes with a channel tag.
package ram_pkg;
	localparam int RAM_NUM_IN    = 4;
	localparam int RAM_NUM_TEMP  = 3;
	localparam int RAM_NUM_CH    = RAM_NUM_IN + RAM_NUM_TEMP;
	localparam int RAM_NUM_FLAG  = RAM_NUM_IN + 2 * RAM_NUM_TEMP + 1;
	localparam int RAM_NUM_DAC   = 12;
	localparam int RAM_RES_W     = 12;
	localparam int RAM_CNT_W     = 9;
	localparam int RAM_LOCAL_IDX = 6;
	// Register indices on the plain register port
	localparam logic [3:0] RAM_REG_STATUS = 4'h0;
	localparam logic [3:0] RAM_REG_CTRL   = 4'h1;
	localparam logic [3:0] RAM_REG_MASK   = 4'h2;
	localparam logic [3:0] RAM_REG_CLRSRC = 4'h3;
	localparam logic [3:0] RAM_REG_CLREN  = 4'h4;
	localparam logic [3:0] RAM_REG_UPPER  = 4'h5;
	localparam logic [3:0] RAM_REG_LOWER  = 4'h6;
	localparam logic [3:0] RAM_REG_HYST   = 4'h7;
	localparam logic [3:0] RAM_REG_CHSEL  = 4'h8;
	// Control, clear source and clear enable register fields
	localparam int RAM_CTRL_LATCH_DIS = 0;
	localparam int RAM_CTRL_INCNT_LSB = 1;
	localparam int RAM_CTRL_TMCNT_LSB = 4;
	localparam int RAM_CTRL_LT_PD     = 6;
	localparam int RAM_CLRSRC_OVH_BIT = 2;
	localparam int RAM_CLREN_LSB      = 3;
	// Reset values: count codes give N = 16 and N = 4
	localparam logic [2:0] RAM_INCNT_RST = 3'h3;
	localparam logic [1:0] RAM_TMCNT_RST = 2'h2;
	localparam logic [RAM_RES_W-1:0] RAM_UPPER_RST = 12'hfff;
	localparam logic [RAM_RES_W-1:0] RAM_LOWER_RST = 12'h000;
	// Die protection: temperature in whole degrees on the local result; then per-channel hysteresis maxima
	localparam logic [RAM_RES_W-1:0] RAM_OVH_LIMIT = 12'h096;
	localparam logic [RAM_RES_W-1:0] RAM_OVH_HYST  = 12'h008;
	localparam logic [6:0] RAM_HYST_IN_MAX = 7'h7f;
	localparam logic [6:0] RAM_HYST_TM_MAX = 7'h1f;

	typedef struct packed {
		logic                 valid;
		logic [2:0]           chan;
		logic [RAM_RES_W-1:0] value;
	} ram_sample_t;

	typedef struct packed {
		logic            wr;
		logic            rd;
		logic [3:0]      addr;
		logic [15:0]     wdata;
	} ram_bus_t;
endpackage

// *** ram_monitor.sv ***
// Range alarm monitor: limit compare, hysteresis, consecutive-sample
// filter, latched status, global alarm and open-drain alarm pin.
// Assumes samples come from logic on clk_i; the over-temperature flag
// steers DAC clear requests that a separate DAC block acts on.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01 - Set overheat flag above 150 degrees
// RULE_02 - Overheat with enables forces DAC clear
// RULE_03 - Overheat protection off when local sensor down
// RULE_04 - Global alarm is OR of status
// RULE_05 - Latched bits stay until resolved and read
// RULE_06 - Status read clears; active conditions reassert
// RULE_07 - Latch disabled: bits follow condition
// RULE_08 - Alarm pin low while global flag set
// RULE_09 - Mask gates pin, not status
// RULE_10 - Reset clears all status bits
// RULE_11 - Input outside window flags range alarm
// RULE_12 - Temperatures keep separate upper, lower flags
// RULE_13 - Inverted thresholds keep alarm asserted
// RULE_14 - Clear only hysteresis inside limit
// RULE_15 - Programmable hysteresis per channel
// RULE_16 - Overheat hysteresis fixed at eight degrees
// RULE_17 - Set only after N consecutive faults
// RULE_18 - Input count code selects 1 to 256
// RULE_19 - Temperature count code selects 1 to 8
// RULE_20 - In-range sample zeroes fault counter
module ram_monitor
	import ram_pkg::*;
#(
	parameter int NUM_IN   = RAM_NUM_IN,
	parameter int NUM_TEMP = RAM_NUM_TEMP
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire ram_sample_t            sample_i,
	input  wire ram_bus_t               bus_i,
	output logic [15:0]                 rdata_o,
	output logic                        global_alarm_flag_o,
	output logic                        alarm_pin_oe_o,
	output logic                        alarm_pin_o,
	output logic [RAM_NUM_DAC-1:0]      dac_clear_req_o
);
	localparam int NCH = NUM_IN + NUM_TEMP;

	// Flag layout: inputs, then upper/lower per temperature, then overheat
	logic [RAM_NUM_FLAG-1:0]  status_r;
	logic [RAM_NUM_FLAG-1:0]  status_nxt;
	logic [RAM_NUM_FLAG-1:0]  mask_r;
	logic [6:0]               ctrl_r;
	logic [15:0]              clrsrc_r;
	logic [15:0]              clren_r;
	logic [2:0]               chsel_r;
	logic [RAM_RES_W-1:0]     upper_r [NCH];
	logic [RAM_RES_W-1:0]     lower_r [NCH];
	logic [6:0]               hyst_r  [NCH];
	logic                     ovh_act_r;
	logic                     ovh_act_nxt;
	logic [15:0]              rdata_r;
	logic                     galarm_r;
	logic                     pin_oe_r;
	logic [RAM_NUM_DAC-1:0]   dac_clr_r;

	logic [RAM_NUM_FLAG-1:0]  cond;
	logic [RAM_CNT_W-1:0]     n_in;
	logic [RAM_CNT_W-1:0]     n_tm;
	logic                     st_rd;
	logic                     lt_down;
	logic                     latch_dis;
	logic                     ovh_en;
	logic [15:0]              rdata_nxt;
	logic                     galarm_nxt;
	logic                     pin_oe_nxt;
	logic [RAM_NUM_DAC-1:0]   dac_clr_nxt;
	logic                     wr_ctrl;
	logic                     wr_mask;
	logic                     wr_clrsrc;
	logic                     wr_clren;
	logic                     wr_chsel;
	logic                     wr_upper;
	logic                     wr_lower;
	logic                     wr_hyst;

	// Count code to number of consecutive samples
	function automatic logic [RAM_CNT_W-1:0] cnt_decode(
		input logic [2:0] code,
		input logic       temp
	);
		logic [RAM_CNT_W-1:0] n;
		n = '0;
		if (temp)
			n[code[1:0]] = 1'b1; // RULE_19
		else if (code == 3'h0)
			n = 9'h001; // RULE_18
		else
			n[4'(code) + 4'h1] = 1'b1; // RULE_18
		return n;
	endfunction

	// Fault counter: an in-range sample zeroes it, it saturates at N
	function automatic logic [RAM_CNT_W-1:0] cnt_step(
		input logic [RAM_CNT_W-1:0] cnt,
		input logic                 hit,
		input logic                 out,
		input logic [RAM_CNT_W-1:0] n
	);
		logic [RAM_CNT_W-1:0] r;
		r = cnt;
		if (hit && !out)
			r = '0; // RULE_20
		else if (hit && (cnt < n))
			r = cnt + RAM_CNT_W'(1);
		return r;
	endfunction

	// Alarm state: the N-th fault in a row sets, a margin inside clears
	function automatic logic act_step(
		input logic                 act,
		input logic                 hit,
		input logic                 out,
		input logic                 back_in,
		input logic [RAM_CNT_W-1:0] cnt,
		input logic [RAM_CNT_W-1:0] n
	);
		logic r;
		r = act;
		if (hit && out && (cnt + RAM_CNT_W'(1) >= n))
			r = 1'b1; // RULE_17
		else if (hit && back_in)
			r = 1'b0; // RULE_14
		return r;
	endfunction

	// Write strobe for one register index
	function automatic logic wr_hit(
		input ram_bus_t   b,
		input logic [3:0] idx
	);
		return b.wr && (b.addr == idx);
	endfunction

	assign n_in      = cnt_decode(ctrl_r[RAM_CTRL_INCNT_LSB +: 3], 1'b0);
	assign n_tm      = cnt_decode({1'b0, ctrl_r[RAM_CTRL_TMCNT_LSB +: 2]},
		1'b1);
	assign latch_dis = ctrl_r[RAM_CTRL_LATCH_DIS];
	assign lt_down   = ctrl_r[RAM_CTRL_LT_PD];
	assign ovh_en    = !lt_down; // RULE_03
	assign st_rd     = bus_i.rd && (bus_i.addr == RAM_REG_STATUS);
	assign wr_ctrl   = wr_hit(bus_i, RAM_REG_CTRL);
	assign wr_mask   = wr_hit(bus_i, RAM_REG_MASK);
	assign wr_clrsrc = wr_hit(bus_i, RAM_REG_CLRSRC);
	assign wr_clren  = wr_hit(bus_i, RAM_REG_CLREN);
	assign wr_chsel  = wr_hit(bus_i, RAM_REG_CHSEL);
	assign wr_upper  = wr_hit(bus_i, RAM_REG_UPPER);
	assign wr_lower  = wr_hit(bus_i, RAM_REG_LOWER);
	assign wr_hyst   = wr_hit(bus_i, RAM_REG_HYST);

	// Per-channel window compare with hysteresis and fault counters
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		localparam bit IS_T = (c >= NUM_IN);
		logic                 hit;
		logic [RAM_RES_W:0]   v;
		logic [RAM_RES_W:0]   up;
		logic [RAM_RES_W:0]   lo;
		logic [RAM_RES_W:0]   h;
		logic                 hi_out;
		logic                 lo_out;
		logic                 hi_in;
		logic                 lo_in;
		logic [RAM_CNT_W-1:0] n_sel;
		logic                 hi_act_r;
		logic                 lo_act_r;
		logic                 hi_act_nxt;
		logic                 lo_act_nxt;
		logic [RAM_CNT_W-1:0] hi_cnt_r;
		logic [RAM_CNT_W-1:0] lo_cnt_r;
		logic [RAM_CNT_W-1:0] hi_cnt_nxt;
		logic [RAM_CNT_W-1:0] lo_cnt_nxt;
		assign hit    = sample_i.valid && (sample_i.chan == 3'(c));
		assign v      = {1'b0, sample_i.value};
		assign up     = {1'b0, upper_r[c]};
		assign lo     = {1'b0, lower_r[c]};
		assign h      = {6'h00, hyst_r[c]};
		assign hi_out = v > up; // RULE_11
		assign lo_out = v < lo; // RULE_11
		// Leaving the alarm needs a margin; inverted limits never leave
		assign hi_in  = (v + h <= up) && (up >= lo); // RULE_14 RULE_13
		assign lo_in  = (v >= lo + h) && (up >= lo); // RULE_14 RULE_13
		assign n_sel  = IS_T ? n_tm : n_in;
		assign hi_cnt_nxt = cnt_step(hi_cnt_r, hit, hi_out, n_sel);
		assign lo_cnt_nxt = cnt_step(lo_cnt_r, hit, lo_out, n_sel);
		assign hi_act_nxt = act_step(hi_act_r, hit, hi_out, hi_in,
			hi_cnt_r, n_sel); // RULE_17
		assign lo_act_nxt = act_step(lo_act_r, hit, lo_out, lo_in,
			lo_cnt_r, n_sel); // RULE_17

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				hi_act_r <= 1'b0;
				lo_act_r <= 1'b0;
				hi_cnt_r <= '0;
				lo_cnt_r <= '0;
			end else begin
				hi_act_r <= hi_act_nxt;
				lo_act_r <= lo_act_nxt;
				hi_cnt_r <= hi_cnt_nxt;
				lo_cnt_r <= lo_cnt_nxt;
			end
		end

		if (IS_T) begin : g_t
			assign cond[NUM_IN + 2*(c-NUM_IN)]     = hi_act_r; // RULE_12
			assign cond[NUM_IN + 2*(c-NUM_IN) + 1] = lo_act_r; // RULE_12
		end else begin : g_i
			assign cond[c] = hi_act_r || lo_act_r; // RULE_11
		end
	end

	// Die overheat from local sensor result, fixed hysteresis
	logic ovh_hit;
	assign ovh_hit = sample_i.valid && (sample_i.chan == 3'(RAM_LOCAL_IDX));
	// Clear test is only reached at or below the limit, so no wrap
	assign ovh_act_nxt = !ovh_en ? 1'b0 // RULE_03
		: (ovh_hit && (sample_i.value > RAM_OVH_LIMIT)) ? 1'b1 // RULE_01
		: (ovh_hit && (sample_i.value + RAM_OVH_HYST <= RAM_OVH_LIMIT))
			? 1'b0 // RULE_16
		: ovh_act_r;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ovh_act_r <= 1'b0;
		else
			ovh_act_r <= ovh_act_nxt;
	end
	assign cond[RAM_NUM_FLAG-1] = ovh_act_r; // RULE_01

	// Latched: hold until read, a live condition sets again (set wins).
	// Live: follow the condition directly.
	assign status_nxt = latch_dis ? cond // RULE_07
		: (st_rd ? cond : (status_r | cond)); // RULE_05 RULE_06

	always_ff @(posedge clk_i) begin
		if (rst_i)
			status_r <= '0; // RULE_10
		else
			status_r <= status_nxt;
	end

	// Register writes: mask, control, clear source, clear enable and select each in a short block, strobes decoded above
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mask_r <= '1;
		else if (wr_mask)
			mask_r <= bus_i.wdata[RAM_NUM_FLAG-1:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl_r <= {1'b0, RAM_TMCNT_RST, RAM_INCNT_RST, 1'b0};
		else if (wr_ctrl)
			ctrl_r <= bus_i.wdata[6:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			clrsrc_r <= '0;
		else if (wr_clrsrc)
			clrsrc_r <= bus_i.wdata;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			clren_r <= '0;
		else if (wr_clren)
			clren_r <= bus_i.wdata;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			chsel_r <= '0;
		else if (wr_chsel)
			chsel_r <= bus_i.wdata[2:0];
	end

	// Limits and hysteresis sit behind the channel select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NCH; i++) begin
				upper_r[i] <= RAM_UPPER_RST;
				lower_r[i] <= RAM_LOWER_RST;
				hyst_r[i]  <= '0;
			end
		end else if (wr_upper)
			upper_r[chsel_r] <= bus_i.wdata[RAM_RES_W-1:0];
		else if (wr_lower)
			lower_r[chsel_r] <= bus_i.wdata[RAM_RES_W-1:0];
		else if (wr_hyst)
			hyst_r[chsel_r] <= (chsel_r >= 3'(NUM_IN))
				? (bus_i.wdata[6:0] & RAM_HYST_TM_MAX)
				: (bus_i.wdata[6:0] & RAM_HYST_IN_MAX); // RULE_15
	end

	// Read data; unmapped indices read zero
	logic [15:0] rd_mux;
	assign rd_mux =
		(bus_i.addr == RAM_REG_STATUS) ? 16'(status_r) :
		(bus_i.addr == RAM_REG_CTRL)   ? 16'(ctrl_r) :
		(bus_i.addr == RAM_REG_MASK)   ? 16'(mask_r) :
		(bus_i.addr == RAM_REG_CLRSRC) ? clrsrc_r :
		(bus_i.addr == RAM_REG_CLREN)  ? clren_r :
		(bus_i.addr == RAM_REG_CHSEL)  ? 16'(chsel_r) :
		(bus_i.addr == RAM_REG_UPPER)  ? 16'(upper_r[chsel_r]) :
		(bus_i.addr == RAM_REG_LOWER)  ? 16'(lower_r[chsel_r]) :
		(bus_i.addr == RAM_REG_HYST)   ? 16'(hyst_r[chsel_r]) : 16'h0000;

	// Outputs; pin and flag follow the status register by one cycle
	logic ovh_clr;
	assign ovh_clr     = status_r[RAM_NUM_FLAG-1]
		&& clrsrc_r[RAM_CLRSRC_OVH_BIT];
	assign rdata_nxt   = bus_i.rd ? rd_mux : 16'h0000;
	assign galarm_nxt  = |status_r; // RULE_04
	assign pin_oe_nxt  = |(status_r & mask_r); // RULE_08 RULE_09
	assign dac_clr_nxt = ovh_clr
		? clren_r[RAM_CLREN_LSB +: RAM_NUM_DAC] : '0; // RULE_02

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r   <= '0;
			galarm_r  <= 1'b0;
			pin_oe_r  <= 1'b0;
			dac_clr_r <= '0;
		end else begin
			rdata_r   <= rdata_nxt;
			galarm_r  <= galarm_nxt;
			pin_oe_r  <= pin_oe_nxt;
			dac_clr_r <= dac_clr_nxt;
		end
	end

	assign rdata_o             = rdata_r;
	assign global_alarm_flag_o = galarm_r;
	assign alarm_pin_oe_o      = pin_oe_r;
	assign alarm_pin_o         = 1'b0;
	assign dac_clear_req_o     = dac_clr_r;
endmodule

`default_nettype wire

// *** ram_monitor_chk.sv ***
// Checker for the range alarm monitor, bound to every ram_monitor.
// Sees only the top ports; one clock domain, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ram_monitor_chk
	import ram_pkg::*;
(
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire ram_sample_t            sample_i,
	input wire ram_bus_t               bus_i,
	input wire logic [15:0]            rdata_o,
	input wire logic                   global_alarm_flag_o,
	input wire logic                   alarm_pin_oe_o,
	input wire logic                   alarm_pin_o,
	input wire logic [RAM_NUM_DAC-1:0] dac_clear_req_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_pin_drive_low: assert property (alarm_pin_o == 1'b0)
		else $error("alarm pin drives a high level");
	a_pin_needs_glob: assert property (alarm_pin_oe_o |->
		global_alarm_flag_o)
		else $error("alarm pin active without global flag");
	a_glob_matches_read: assert property ($past(bus_i.rd &&
		bus_i.addr == RAM_REG_STATUS) |->
		global_alarm_flag_o == (rdata_o[10:0] != 11'h000))
		else $error("global flag differs from status OR");
	// One cycle of slack: the clear request comes from the latched status, like the flag
	a_dac_needs_glob: assert property (dac_clear_req_o != '0 |->
		##[0:1] global_alarm_flag_o)
		else $error("dac clear without overheat alarm");
	a_reset_flags: assert property ($past(rst_i) |->
		!global_alarm_flag_o && !alarm_pin_oe_o)
		else $error("alarm flags set after reset");
	a_reset_outs: assert property ($past(rst_i) |->
		dac_clear_req_o == '0 && rdata_o == 16'h0000)
		else $error("outputs not zero after reset");
	a_unmapped_read: assert property ($past(bus_i.rd &&
		bus_i.addr > RAM_REG_CHSEL) |-> rdata_o == 16'h0000)
		else $error("unmapped register read not zero");
	a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0000)
		else $error("read data outside read cycle");
endmodule
bind ram_monitor ram_monitor_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.sample_i(sample_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.global_alarm_flag_o(global_alarm_flag_o),
	.alarm_pin_oe_o(alarm_pin_oe_o), .alarm_pin_o(alarm_pin_o),
	.dac_clear_req_o(dac_clear_req_o));
`default_nettype wire

// *** ram_host.sv ***
// Host side of the alarm line: pull-up resistor on the open-drain pin.
// Assumes the enable is high while the monitor pulls the line.
`timescale 1ns/1ps
`default_nettype none
module ram_host (
	input  wire logic alarm_pin_oe_i,
	input  wire logic alarm_pin_i,
	output logic      alarm_line_o
);
	// Released line floats up to the pull-up, never holds the old value
	assign alarm_line_o = alarm_pin_oe_i ? alarm_pin_i : 1'b1;
endmodule
`default_nettype wire

// *** range_alarm_monitor_tb.sv ***
// Self-checking bench for ram_monitor with the host pull-up model.
// Assumes one 125 MHz clock and the register map of ram_pkg.
`timescale 1ns/1ps
`default_nettype none
module range_alarm_monitor_tb;
	import ram_pkg::*;
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	ram_sample_t            smp_d = '0;
	ram_bus_t               bus_d = '0;
	wire logic [15:0]       rdata;
	wire logic              glob;
	wire logic              oe;
	wire logic              pin;
	wire logic              line;
	wire logic [11:0]       dac;
	int                     fails = 0;
	int                     checks = 0;
	int                     seed = 32'h3b39;
	int                     i, j, n, c, h, r;
	logic [15:0]            bitv;
	ram_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i), .sample_i(smp_d),
		.bus_i(bus_d), .rdata_o(rdata), .global_alarm_flag_o(glob),
		.alarm_pin_oe_o(oe), .alarm_pin_o(pin), .dac_clear_req_o(dac));
	ram_host i_host (.alarm_pin_oe_i(oe), .alarm_pin_i(pin),
		.alarm_line_o(line));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		bus_d <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		bus_d <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		bus_d <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_i);
		bus_d <= '0;
		#1;
		chk(rdata, e);
	endtask
	task automatic smp(input logic [2:0] ch, input logic [11:0] v);
		@(posedge clk_i);
		smp_d <= '{valid: 1'b1, chan: ch, value: v};
		@(posedge clk_i);
		smp_d <= '0;
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_i);
		fails++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(RAM_REG_CTRL, 16'h0026);
		rd(RAM_REG_MASK, 16'h07ff);
		wr(RAM_REG_STATUS, 16'hffff);
		rd(RAM_REG_STATUS, 16'h0000);
		rd(4'h9, 16'h0000);
		wr(RAM_REG_CHSEL, 16'h0000);
		rd(RAM_REG_UPPER, 16'h0fff);
		wr(RAM_REG_UPPER, 16'h0800);
		wr(RAM_REG_CHSEL, 16'h0004);
		wr(RAM_REG_UPPER, 16'h0800);
		// Every count code, with an in-range sample breaking the run
		for (i = 0; i < 12; i++) begin
			c = i < 8 ? 0 : 4;
			n = i < 8 ? (i == 0 ? 1 : 2 << i) : 1 << (i - 8);
			bitv = i < 8 ? 16'h0001 : 16'h0010;
			wr(RAM_REG_CTRL, 16'(i < 8 ? (i << 1) | 32 : 6 | ((i - 8) << 4)));
			repeat (n - 1) smp(3'(c), 12'h900);
			smp(3'(c), 12'h100);
			repeat (n - 1) smp(3'(c), 12'h900);
			cyc(3);
			rd(RAM_REG_STATUS, 16'h0000);
			smp(3'(c), 12'h900);
			cyc(3);
			chk({15'h0, glob}, 16'h0001);
			chk({15'h0, line}, 16'h0000);
			rd(RAM_REG_STATUS, bitv);
			rd(RAM_REG_STATUS, bitv);
			smp(3'(c), 12'h100);
			cyc(3);
			rd(RAM_REG_STATUS, bitv);
			rd(RAM_REG_STATUS, 16'h0000);
		end
		wr(RAM_REG_CTRL, 16'h0001);
		for (j = 0; j < 2; j++) begin
			r = $random(seed) & 32'h7fffffff;
			c = j ? 5 : 1 + r % 3;
			h = j ? r % 32 : r % 128;
			bitv = j ? 16'h0080 : 16'(1 << c);
			wr(RAM_REG_CHSEL, 16'(c));
			wr(RAM_REG_LOWER, 16'h0400);
			wr(RAM_REG_HYST, 16'(h));
			smp(3'(c), 12'h3ff);
			cyc(3);
			rd(RAM_REG_STATUS, bitv);
			smp(3'(c), 12'(12'h3ff + h));
			cyc(3);
			chk({15'h0, glob}, 16'h0001);
			smp(3'(c), 12'(12'h400 + h));
			cyc(3);
			chk({15'h0, glob}, 16'h0000);
		end
		wr(RAM_REG_MASK, 16'h0000);
		smp(3'h0, 12'h900);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0001);
		chk({15'h0, line}, 16'h0001);
		wr(RAM_REG_MASK, 16'h07ff);
		cyc(2);
		chk({15'h0, line}, 16'h0000);
		smp(3'h0, 12'h100);
		cyc(3);
		chk({15'h0, line}, 16'h0001);
		wr(RAM_REG_CHSEL, 16'h0002);
		wr(RAM_REG_UPPER, 16'h0100);
		wr(RAM_REG_LOWER, 16'h0200);
		smp(3'h2, 12'h150);
		smp(3'h2, 12'h180);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0004);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(RAM_REG_STATUS, 16'h0000);
		chk({15'h0, glob}, 16'h0000);
		wr(RAM_REG_CTRL, 16'h0001);
		r = $random(seed);
		wr(RAM_REG_CLRSRC, 16'h0004);
		wr(RAM_REG_CLREN, 16'(r) & 16'h7ff8);
		smp(3'h6, 12'h096);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0000);
		smp(3'h6, 12'h097);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0400);
		chk({4'h0, dac}, {4'h0, 12'(r >> 3)});
		smp(3'h6, 12'h08f);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0400);
		smp(3'h6, 12'h08e);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0000);
		smp(3'h6, 12'h0a0);
		wr(RAM_REG_CTRL, 16'h0041);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0000);
		smp(3'h6, 12'h0a0);
		cyc(3);
		rd(RAM_REG_STATUS, 16'h0000);
		chk({4'h0, dac}, 16'h0000);
		conclude();
	end
endmodule
`default_nettype wire
